// ===== rtl/adcsd_command_decoder.sv
// serial command decoder: byte receiver, register file, scan set derivation
`include "adcsd_cfg.svh"
module adcsd_command_decoder
   import adcsd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cs_n_pin,
   input  wire logic        sclk_pin,
   input  wire logic        din_pin,
   input  wire logic        convert_start_pin_n,
   input  wire logic        fifo_empty,
   input  wire logic [11:0] fifo_data,
   input  wire logic [5:0]  samples_per_result,
   input  wire logic [5:0]  repeat_results,
   output logic             dout_pin,
   output logic             fifo_pop,
   output logic             fifo_clear,
   output logic             scan_start,
   output logic [3:0]       channel_sel,
   output logic [1:0]       scan_mode,
   output logic             temp_request,
   output logic [1:0]       clock_mode,
   output logic [1:0]       reference_mode,
   output logic [1:0]       pair_reg_addr,
   output logic [7:0]       unipolar_pair_flag,
   output logic [7:0]       bipolar_pair_flag,
   output logic             averaging_enable,
   output logic [1:0]       average_count,
   output logic [1:0]       repeat_count,
   output logic             shared_pin_is_convert_start,
   output logic             averaging_active,
   output logic [15:0]      convert_mask,
   output logic [7:0]       pair_twos_complement,
   output logic [6:0]       result_count,
   output logic [23:0]      scan_time_cycles
);
   // ------------------------------
   // reset release and pin synchronisers
   // ------------------------------
   logic [1:0]      rst_sync;
   logic            rst_core_n;
   logic [3:0]      pin_meta;
   logic [3:0]      pin_sync;
   logic            cs_last;
   logic            sclk_last;
   logic            cnv_last;
   logic            sync_cs_n;
   logic            sync_sclk;
   logic            sync_din;
   logic            sync_cnv_n;
   logic            cs_active;
   logic            cs_fall;
   logic            cs_rise;
   logic            sclk_rise;
   logic            sclk_fall;
   logic            cnv_fall;

   // release is delayed two edges so no flop leaves reset on a ragged edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_core_n = rst_sync[1];

   // two flops on every pin; the first stage feeds only the second
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         pin_meta <= 4'h9;
         pin_sync <= 4'h9;
      end else begin
         pin_meta <= {cs_n_pin, sclk_pin, din_pin, convert_start_pin_n};
         pin_sync <= pin_meta;
      end
   end
   assign sync_cs_n  = pin_sync[3];
   assign sync_sclk  = pin_sync[2];
   assign sync_din   = pin_sync[1];
   assign sync_cnv_n = pin_sync[0];

   // previous synced levels for edge finding
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         cs_last   <= 1'b1;
         sclk_last <= 1'b0;
         cnv_last  <= 1'b1;
      end else begin
         cs_last   <= sync_cs_n;
         sclk_last <= sync_sclk;
         cnv_last  <= sync_cnv_n;
      end
   end
   assign cs_active = ~sync_cs_n;
   assign cs_fall   = ~sync_cs_n & cs_last;
   assign cs_rise   = sync_cs_n & ~cs_last;
   assign sclk_rise = cs_active & sync_sclk & ~sclk_last;
   assign sclk_fall = ~sync_sclk & sclk_last;
   assign cnv_fall  = ~sync_cnv_n & cnv_last;

   // ------------------------------
   // byte receiver
   // ------------------------------
   logic [6:0]      rx_shift;
   logic [2:0]      rx_bit_cnt;
   logic            byte_done;
   logic [7:0]      rx_byte;
   adcsd_rx_state_t rx_state;

   // din is taken on serial clock rising edges, msb first
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         rx_shift   <= 7'h00;
         rx_bit_cnt <= 3'h0;
      end else if (cs_fall | cs_rise) begin
         rx_bit_cnt <= 3'h0;
      end else if (sclk_rise) begin
         rx_shift   <= {rx_shift[5:0], sync_din};
         rx_bit_cnt <= rx_bit_cnt + 3'h1;
      end
   end
   assign byte_done = sclk_rise & (rx_bit_cnt == 3'h7);
   assign rx_byte   = {rx_shift, sync_din};

   // ------------------------------
   // command classification
   // ------------------------------
   logic wr_conv;
   logic wr_setup;
   logic wr_avg;
   logic wr_reset;
   logic wr_pair;
   logic soft_reset;
   logic in_cmd;

   assign in_cmd     = byte_done & (rx_state == RX_COMMAND);
   assign wr_conv    = in_cmd & rx_byte[7]; // [R1]
   assign wr_setup   = in_cmd & (rx_byte[7:6] == 2'b01); // [R1]
   assign wr_avg     = in_cmd & (rx_byte[7:5] == 3'b001); // [R1]
   assign wr_reset   = in_cmd & (rx_byte[7:4] == 4'b0001); // [R1]
   assign wr_pair    = byte_done & (rx_state == RX_PAIR_DATA);
   assign soft_reset = wr_reset & ~rx_byte[`ADCSD_RESET_ACT]; // [R21]

   // a setup byte with address 1x makes the next byte pair data; deselect aborts it
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         rx_state <= RX_COMMAND;
      end else if (cs_rise | soft_reset) begin
         rx_state <= RX_COMMAND;
      end else if (byte_done) begin
         unique case (rx_state)
            RX_COMMAND: begin
               if (wr_setup & rx_byte[`ADCSD_PAIR_HI]) begin
                  rx_state <= RX_PAIR_DATA; // [R14]
               end
            end
            RX_PAIR_DATA: begin
               rx_state <= RX_COMMAND; // [R16]
            end
         endcase
      end
   end

   // ------------------------------
   // register file
   // ------------------------------
   // conversion request fields
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         channel_sel  <= `ADCSD_CHAN_RST; // [R22]
         scan_mode    <= `ADCSD_FIELD2_RST;
         temp_request <= 1'b0;
      end else if (soft_reset) begin
         channel_sel  <= `ADCSD_CHAN_RST; // [R21]
         scan_mode    <= `ADCSD_FIELD2_RST;
         temp_request <= 1'b0;
      end else if (wr_conv) begin
         channel_sel  <= rx_byte[`ADCSD_CHAN_HI:`ADCSD_CHAN_LO]; // [R2]
         scan_mode    <= rx_byte[`ADCSD_SCAN_HI:`ADCSD_SCAN_LO];
         temp_request <= rx_byte[`ADCSD_TEMP_BIT]; // [R9]
      end
   end

   // setup fields; clock mode wakes up in the serial internal mode
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         clock_mode     <= `ADCSD_CLK_RST; // [R22]
         reference_mode <= `ADCSD_FIELD2_RST;
         pair_reg_addr  <= `ADCSD_FIELD2_RST;
      end else if (soft_reset) begin
         clock_mode     <= `ADCSD_CLK_RST; // [R21]
         reference_mode <= `ADCSD_FIELD2_RST;
         pair_reg_addr  <= `ADCSD_FIELD2_RST;
      end else if (wr_setup) begin
         clock_mode     <= rx_byte[`ADCSD_CLK_HI:`ADCSD_CLK_LO]; // [R13]
         reference_mode <= rx_byte[`ADCSD_REF_HI:`ADCSD_REF_LO]; // [R13]
         pair_reg_addr  <= rx_byte[`ADCSD_PAIR_HI:`ADCSD_PAIR_LO]; // [R13]
      end
   end

   // averaging fields are kept raw; the sequencer owns their meaning
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         averaging_enable <= 1'b0; // [R22]
         average_count    <= `ADCSD_FIELD2_RST;
         repeat_count     <= `ADCSD_FIELD2_RST;
      end else if (soft_reset) begin
         averaging_enable <= 1'b0; // [R21]
         average_count    <= `ADCSD_FIELD2_RST;
         repeat_count     <= `ADCSD_FIELD2_RST;
      end else if (wr_avg) begin
         averaging_enable <= rx_byte[`ADCSD_AVG_EN_BIT]; // [R19]
         average_count    <= rx_byte[`ADCSD_AVG_CNT_HI:`ADCSD_AVG_CNT_LO]; // [R27]
         repeat_count     <= rx_byte[`ADCSD_REP_HI:`ADCSD_REP_LO]; // [R27]
      end
   end

   // pair data goes where the latched address points; 0x never gets here
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         unipolar_pair_flag <= `ADCSD_PAIR_RST; // [R22]
         bipolar_pair_flag  <= `ADCSD_PAIR_RST;
      end else if (soft_reset) begin
         unipolar_pair_flag <= `ADCSD_PAIR_RST; // [R21]
         bipolar_pair_flag  <= `ADCSD_PAIR_RST;
      end else if (wr_pair) begin
         if (pair_reg_addr[`ADCSD_PAIR_LO]) begin
            bipolar_pair_flag <= rx_byte; // [R14]
         end else begin
            unipolar_pair_flag <= rx_byte; // [R14]
         end
      end
   end

   // ------------------------------
   // actions: fifo clear and scan start
   // ------------------------------
   logic scan_go;

   // a full reset also empties the fifo, so both reset flavours pulse it
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         fifo_clear <= 1'b0;
      end else begin
         fifo_clear <= wr_reset; // [R21]
      end
   end

   // start is held back one edge so the derived scan set is settled when it fires
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         scan_go    <= 1'b0;
         scan_start <= 1'b0;
      end else begin
         scan_go    <= clock_mode[1] ? wr_conv : cnv_fall; // [R12]
         scan_start <= scan_go;
      end
   end

   // ------------------------------
   // scan set derivation
   // ------------------------------
   logic        next_shared_cnv;
   logic        next_avg_active;
   logic [15:0] pin_excluded;
   logic [15:0] next_convert_mask;
   logic [7:0]  next_twos;
   logic [6:0]  next_result_count;
   logic [23:0] next_scan_time;

   // is channel c inside the range that the scan field asks for
   function automatic logic in_range(input logic [3:0] c, input logic [3:0] n,
                                     input logic [1:0] mode);
      unique case (adcsd_scan_t'(mode))
         SCAN_UP_TO_N:  in_range = (c <= n); // [R4]
         SCAN_FROM_N:   in_range = (c >= n); // [R5]
         SCAN_REPEAT_N: in_range = (c == n); // [R6]
         SCAN_SINGLE_N: in_range = (c == n); // [R7]
      endcase
   endfunction

   assign next_shared_cnv = ~clock_mode[1]; // [R26]
   assign next_avg_active = averaging_enable &
                            (adcsd_clk_mode_t'(clock_mode) != CLK_SERIAL_EXTERNAL); // [R20]
   assign pin_excluded =
      ({16{next_shared_cnv}} & (16'h0001 << `ADCSD_TOP_CH)) |
      ({16{adcsd_ref_mode_t'(reference_mode) == REF_EXT_DIFF}} &
       (16'h0001 << `ADCSD_REFN_CH)); // [R10]

   // each pair owns two channels; a differential pair reports on its lower one
   genvar p;
   generate
      for (p = 0; p < 8; p++) begin : g_pair
         logic diff;
         logic lo_in;
         logic hi_in;
         assign diff  = unipolar_pair_flag[7 - p] | bipolar_pair_flag[7 - p]; // [R24]
         assign lo_in = in_range(4'(2 * p), channel_sel, scan_mode);
         assign hi_in = in_range(4'(2 * p + 1), channel_sel, scan_mode);
         assign next_convert_mask[2 * p] = diff ?
            (lo_in & ~pin_excluded[2 * p] & ~pin_excluded[2 * p + 1]) : // [R11]
            (lo_in & ~pin_excluded[2 * p]); // [R10]
         assign next_convert_mask[2 * p + 1] = ~diff & hi_in &
                                               ~pin_excluded[2 * p + 1]; // [R8]
         assign next_twos[p] = bipolar_pair_flag[7 - p] &
                               ~unipolar_pair_flag[7 - p]; // [R17] [R18]
      end
   endgenerate

   // result count and internally timed scan duration
   always_comb begin
      logic [6:0]  mask_cnt;
      logic [23:0] navg;
      mask_cnt = 7'h00;
      navg = next_avg_active ? 24'(samples_per_result) : 24'h000001; // [R19]
      for (int i = 0; i < 16; i++) begin
         mask_cnt = mask_cnt + 7'(next_convert_mask[i]); // [R8]
      end
      if (adcsd_scan_t'(scan_mode) == SCAN_REPEAT_N) begin
         next_result_count = (mask_cnt != 7'h00) ? 7'(repeat_results) : 7'h00; // [R6]
      end else begin
         next_result_count = mask_cnt;
      end
      next_result_count = next_result_count + 7'(temp_request); // [R9]
      next_scan_time = 24'(`ADCSD_T_CNV_CYC) * navg * 24'(next_result_count); // [R23]
      if (temp_request) begin
         next_scan_time = next_scan_time + 24'(`ADCSD_T_TS_CYC);
      end
      if (adcsd_ref_mode_t'(reference_mode) == REF_INT_SLEEP) begin
         next_scan_time = next_scan_time + 24'(`ADCSD_T_RP_CYC);
      end
      if (clock_mode[0]) begin
         next_scan_time = 24'h000000; // externally timed modes have no fixed duration
      end
   end

   // all derived outputs are registered
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         shared_pin_is_convert_start <= 1'b0;
         averaging_active            <= 1'b0;
         convert_mask                <= 16'h0000;
         pair_twos_complement        <= 8'h00;
         result_count                <= 7'h00;
         scan_time_cycles            <= 24'h000000;
      end else begin
         shared_pin_is_convert_start <= next_shared_cnv; // [R26]
         averaging_active            <= next_avg_active; // [R19] [R20]
         convert_mask                <= next_convert_mask;
         pair_twos_complement        <= next_twos; // [R18]
         result_count                <= next_result_count;
         scan_time_cycles            <= next_scan_time; // [R23]
      end
   end

   // ------------------------------
   // result output
   // ------------------------------
   adcsd_result_shifter u_shifter (
      .clk,
      .rst_core_n,
      .cs_fall,
      .cs_active,
      .sclk_fall,
      .fifo_empty,
      .fifo_data,
      .fifo_pop,
      .dout       (dout_pin)
   );
endmodule // adcsd_command_decoder

// ===== rtl/adcsd_cfg.svh
// constants for the adc serial command decoder: field positions, reset values, timing
// Function
// [R1] leading bits of a command byte pick conversion, setup, averaging or reset register
// [R2] conversion bits 6..3 give the binary channel number, inputs 0 to 15
// [R3] host names a differential pair by the number of its lower channel
// [R4] scan field 00 converts channels 0 up to and including channel n
// [R5] scan field 01 converts channel n up to the top channel
// [R6] scan field 10 repeats channel n, result count from averaging register scan count
// [R7] scan field 11 gives exactly one result from channel n
// [R8] range scans give one result per channel or pair, plus temperature if asked
// [R9] conversion lsb set asks one temperature result, placed first in the scan
// [R10] no conversion on a pin serving as convert start or negative reference
// [R11] top pair dropped when either of its pins is convert start or negative reference
// [R12] scan starts on conversion write in clock modes 1x, convert start pulse in 0x
// [R13] setup bits 5:4 clock mode, 3:2 reference mode, 1:0 pair register address
// [R14] pair address 10 sends next byte to unipolar, 11 to bipolar pair register
// [R15] host holds chip select low for 16 serial clocks on a setup with data
// [R16] pair address 00 or 01 leaves pair registers alone, next byte is a command
// [R17] a pair flagged both unipolar and bipolar is treated as unipolar
// [R18] unipolar results straight binary, bipolar differential results two's complement
// [R19] averaging enable bit 4 averages up to 32 samples per result in all scans except in clock mode 11
// [R20] clock mode 11 ignores averaging settings
// [R21] reset write with action 1 clears fifo only, with 0 restores power-up state
// [R22] power-up clears all registers to zero except clock mode which is 10
// [R23] internal scan time is sample time times averages times results plus extras
// [R24] pair register bit 7 flags inputs 0 and 1, down to bit 0 for 14 and 15
// [R25] results go out as two bytes msb first, four zeros first, empty fifo reads zero
// [R26] shared pin is convert start in clock modes 0x and analog input in 1x
// [R27] averaging and scan count fields are stored raw and handed to the sequencer
`ifndef ADCSD_CFG_SVH
`define ADCSD_CFG_SVH
// ------------------------------
// command byte fields
// ------------------------------
`define ADCSD_CHAN_HI      6
`define ADCSD_CHAN_LO      3
`define ADCSD_SCAN_HI      2
`define ADCSD_SCAN_LO      1
`define ADCSD_TEMP_BIT     0
`define ADCSD_CLK_HI       5
`define ADCSD_CLK_LO       4
`define ADCSD_REF_HI       3
`define ADCSD_REF_LO       2
`define ADCSD_PAIR_HI      1
`define ADCSD_PAIR_LO      0
`define ADCSD_AVG_EN_BIT   4
`define ADCSD_AVG_CNT_HI   3
`define ADCSD_AVG_CNT_LO   2
`define ADCSD_REP_HI       1
`define ADCSD_REP_LO       0
`define ADCSD_RESET_ACT    3
// ------------------------------
// reset values and channel map
// ------------------------------
`define ADCSD_CHAN_RST     4'h0
`define ADCSD_FIELD2_RST   2'h0
`define ADCSD_CLK_RST      2'h2
`define ADCSD_PAIR_RST     8'h00
`define ADCSD_TOP_CH       15
`define ADCSD_REFN_CH      14
// ------------------------------
// timing
// ------------------------------
`define ADCSD_CLK_MHZ      100
`define ADCSD_T_CNV_NS     3500
`define ADCSD_T_TS_NS      2000
`define ADCSD_T_RP_NS      20000
`define ADCSD_T_CNV_CYC    ((`ADCSD_T_CNV_NS * `ADCSD_CLK_MHZ + 999) / 1000)
`define ADCSD_T_TS_CYC     ((`ADCSD_T_TS_NS * `ADCSD_CLK_MHZ + 999) / 1000)
`define ADCSD_T_RP_CYC     ((`ADCSD_T_RP_NS * `ADCSD_CLK_MHZ + 999) / 1000)
`endif

// ===== rtl/adcsd_pkg.sv
// types shared by the adc serial command decoder
package adcsd_pkg;
   // ------------------------------
   // receiver state and field encodings
   // ------------------------------
   typedef enum logic {RX_COMMAND, RX_PAIR_DATA} adcsd_rx_state_t;
   typedef enum logic [1:0] {
      SCAN_UP_TO_N, SCAN_FROM_N, SCAN_REPEAT_N, SCAN_SINGLE_N
   } adcsd_scan_t;
   typedef enum logic [1:0] {
      CLK_PIN_INTERNAL, CLK_PIN_EXTERNAL, CLK_SERIAL_INTERNAL, CLK_SERIAL_EXTERNAL
   } adcsd_clk_mode_t;
   typedef enum logic [1:0] {
      REF_INT_SLEEP, REF_EXT_SINGLE, REF_INT_ON, REF_EXT_DIFF
   } adcsd_ref_mode_t;
endpackage

// ===== rtl/adcsd_result_shifter.sv
// shifts fifo results out msb first, one bit per serial clock falling edge
module adcsd_result_shifter
   import adcsd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_core_n,
   input  wire logic        cs_fall,
   input  wire logic        cs_active,
   input  wire logic        sclk_fall,
   input  wire logic        fifo_empty,
   input  wire logic [11:0] fifo_data,
   output logic             fifo_pop,
   output logic             dout
);
   logic [15:0] out_shift;
   logic [3:0]  out_bit_cnt;
   logic        word_load;
   logic [15:0] next_word;

   // load at select and after the last bit of each word; empty fifo gives zeros
   assign word_load = cs_fall | (cs_active & sclk_fall & (out_bit_cnt == 4'hf));
   assign next_word = fifo_empty ? 16'h0000 : {4'h0, fifo_data}; // [R25]

   // ------------------------------
   // output shift register
   // ------------------------------
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         out_shift   <= 16'h0000;
         out_bit_cnt <= 4'h0;
      end else if (word_load) begin
         out_shift   <= next_word; // [R25]
         out_bit_cnt <= 4'h0;
      end else if (cs_active & sclk_fall) begin
         out_shift   <= {out_shift[14:0], 1'b0}; // [R25]
         out_bit_cnt <= out_bit_cnt + 4'h1;
      end
   end

   // pop one entry per word taken, so the fifo pointer tracks what left the pin
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         fifo_pop <= 1'b0;
      end else begin
         fifo_pop <= word_load & ~fifo_empty;
      end
   end

   // the line idles low while deselected
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         dout <= 1'b0;
      end else if (word_load) begin
         dout <= next_word[15];
      end else if (cs_active & sclk_fall) begin
         dout <= out_shift[14];
      end else if (!cs_active) begin
         dout <= 1'b0;
      end
   end
endmodule // adcsd_result_shifter

// ===== verification/adcsd_asserts.sv
// concurrent checks on the command decoder ports
module adcsd_asserts (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        cs_n_pin,
   input wire logic        dout_pin,
   input wire logic        fifo_clear,
   input wire logic        scan_start,
   input wire logic [1:0]  clock_mode,
   input wire logic [7:0]  unipolar_pair_flag,
   input wire logic [7:0]  bipolar_pair_flag,
   input wire logic        averaging_enable,
   input wire logic        shared_pin_is_convert_start,
   input wire logic        averaging_active,
   input wire logic [15:0] convert_mask,
   input wire logic [7:0]  pair_twos_complement,
   input wire logic [23:0] scan_time_cycles
);
   timeunit 1ns; timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // format bit p belongs to pair p, which sits at flag bit 7 - p
   wire logic [7:0] twos_raw = bipolar_pair_flag & ~unipolar_pair_flag;
   wire logic [7:0] twos_ref = {twos_raw[0], twos_raw[1], twos_raw[2], twos_raw[3],
                                twos_raw[4], twos_raw[5], twos_raw[6], twos_raw[7]};
   // derived outputs trail the registers by one clock
   shared_pin_a: assert property (shared_pin_is_convert_start == !$past(clock_mode[1]))
      else $error("shared pin role wrong");
   avg_active_a: assert property (averaging_active ==
      $past(averaging_enable && clock_mode != 2'h3)) else $error("averaging active wrong");
   twos_comp_a: assert property (pair_twos_complement == $past(twos_ref))
      else $error("pair format wrong");
   clear_pulse_a: assert property (fifo_clear |=> !fifo_clear)
      else $error("clear not a pulse");
   start_pulse_a: assert property (scan_start |=> !scan_start)
      else $error("start not a pulse");
   ext_time_a: assert property ($past(clock_mode[0]) |-> scan_time_cycles == 24'h0)
      else $error("scan time not zero");
   top_chan_a: assert property ($past(!clock_mode[1]) |-> !convert_mask[15])
      else $error("convert start pin converted");
   // six idle cycles cover the select sync delay
   dout_idle_a: assert property (cs_n_pin [*6] |-> !dout_pin)
      else $error("dout busy idle");
endmodule // adcsd_asserts
bind adcsd_command_decoder adcsd_asserts i_chk (.clk, .rst_n, .cs_n_pin, .dout_pin, .fifo_clear,
   .scan_start, .clock_mode, .unipolar_pair_flag, .bipolar_pair_flag, .averaging_enable,
   .shared_pin_is_convert_start, .averaging_active, .convert_mask, .pair_twos_complement,
   .scan_time_cycles);

// ===== verification/adcsd_host_model.sv
// serial host: shifts bytes in msb first, reads dout on each rise
module adcsd_host_model (
   input wire logic clk,
   input wire logic dout_pin,
   output logic     cs_n_pin,
   output logic     sclk_pin,
   output logic     din_pin
);
   timeunit 1ns; timeprecision 1ps;
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      din_pin = 1'b0;
   end
   // sends the top n bits of d; sclk stands still outside frames
   task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] q);
      q = 16'h0;
      @(negedge clk) cs_n_pin <= 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 15; i > 15 - n; i--) begin
         din_pin <= d[i];
         repeat (4) @(negedge clk);
         sclk_pin <= 1'b1;
         q = {q[14:0], dout_pin};
         repeat (4) @(negedge clk);
         sclk_pin <= 1'b0;
      end
      repeat (8) @(negedge clk);
      cs_n_pin <= 1'b1;
      din_pin <= ~din_pin; // released line must not look valid
      repeat (8) @(negedge clk);
   endtask
endmodule // adcsd_host_model

// ===== verification/tb.sv
// self-checking bench for the command decoder
`include "adcsd_cfg.svh"
module tb;
   timeunit 1ns; timeprecision 1ps;
   logic clk, rst_n, cs_n, sclk, din, cnv_n, f_empty, dout, f_clr, start, temp, avg_en, shr, avg_act;
   logic [11:0] f_data;
   logic [5:0]  spr, rep;
   logic [3:0]  chan;
   logic [1:0]  scan, ckm, refm, paddr, avgc, repc;
   logic [7:0]  uni, bip, p2c, b;
   logic [15:0] mask, q;
   logic [6:0]  rcnt;
   logic [23:0] stime;
   int          n_fail = 0, compares = 0, n_start = 0, n_clr = 0, k, seed = 32'h38f8d37c;
   adcsd_command_decoder i_dut (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .din_pin(din), .convert_start_pin_n(cnv_n), .fifo_empty(f_empty), .fifo_data(f_data),
      .samples_per_result(spr), .repeat_results(rep), .dout_pin(dout), .fifo_pop(),
      .fifo_clear(f_clr), .scan_start(start), .channel_sel(chan), .scan_mode(scan),
      .temp_request(temp), .clock_mode(ckm), .reference_mode(refm), .pair_reg_addr(paddr),
      .unipolar_pair_flag(uni), .bipolar_pair_flag(bip), .averaging_enable(avg_en),
      .average_count(avgc), .repeat_count(repc), .shared_pin_is_convert_start(shr),
      .averaging_active(avg_act), .convert_mask(mask), .pair_twos_complement(p2c),
      .result_count(rcnt), .scan_time_cycles(stime));
   adcsd_host_model i_host (.clk(clk), .dout_pin(dout), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .din_pin(din));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // pulses are counted, so short ones are never missed
   always @(posedge clk) begin
      if (start === 1'b1) n_start++;
      if (f_clr === 1'b1) n_clr++;
   end
   initial begin
      #500000;
      n_fail++;
      finish_test();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // expectations: mode 10, reference 00, no pairs
   // ----------------------------------------
   function automatic logic [15:0] exp_mask(input logic [7:0] c);
      if (c[2:1] == 2'h0) return 16'hffff >> (4'hf - c[6:3]);
      if (c[2:1] == 2'h1) return 16'hffff << c[6:3];
      return 16'h1 << c[6:3];
   endfunction
   function automatic logic [6:0] exp_cnt(input logic [7:0] c);
      logic [6:0] n;
      case (c[2:1])
         2'h0: n = 7'(c[6:3]) + 7'h1;
         2'h1: n = 7'h10 - 7'(c[6:3]);
         2'h2: n = 7'(rep);
         default: n = 7'h1;
      endcase
      return n + 7'(c[0]);
   endfunction
   initial begin
      rst_n = 1'b0; cnv_n = 1'b1; f_empty = 1'b1; f_data = 12'h0; spr = 6'h1; rep = 6'h1;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk(ckm, 2'h2);
      chk({uni, bip, chan, scan, temp, refm}, 24'h0);
      repeat (8) @(negedge clk);
      for (int i = 0; i < 14; i++) begin
         b = i == 0 ? 8'h81 : i == 1 ? 8'hfa : {1'b1, 7'($random(seed))};
         rep = 6'($random(seed)) | 6'h1;
         k = n_start;
         i_host.xfer({b, 8'h0}, 8, q);
         chk({chan, scan, temp}, b[6:0]);
         chk(24'(n_start - k), 24'h1);
         chk(rcnt, exp_cnt(b));
         if (b[2:1] != 2'h2) chk(mask, exp_mask(b));
         if (!b[0]) chk(stime, `ADCSD_T_CNV_CYC * exp_cnt(b) + `ADCSD_T_RP_CYC);
      end
      $display("conversion test done");
      i_host.xfer(16'h62a5, 16, q);
      i_host.xfer(16'h633c, 16, q);
      chk({uni, bip}, 16'ha53c);
      chk(p2c, 8'h18);
      i_host.xfer(16'h613e, 16, q);
      chk({uni, bip, paddr}, 18'h294f1);
      chk({avg_en, avgc, repc, avg_act}, 6'h3d);
      i_host.xfer(16'ha600, 8, q);
      chk(mask, 16'h0010);
      $display("setup test done");
      f_empty = 1'b0;
      f_data = 12'($random(seed));
      i_host.xfer(16'h0, 16, q);
      chk(q, {4'h0, f_data});
      f_empty = 1'b1;
      i_host.xfer(16'h0, 16, q);
      chk(q, 16'h0);
      $display("readout test done");
      i_host.xfer(16'h4000, 8, q);
      k = n_start;
      i_host.xfer(16'h9800, 8, q);
      chk({shr, 24'(n_start - k)}, 25'h1000000);
      cnv_n = 1'b0;
      repeat (4) @(negedge clk);
      cnv_n = 1'b1;
      repeat (8) @(negedge clk);
      chk(24'(n_start - k), 24'h1);
      i_host.xfer(16'h7000, 8, q);
      chk({avg_act, stime}, 25'h0);
      i_host.xfer(16'h1800, 8, q);
      chk({ckm, avg_en, 24'(n_clr)}, 27'h7000001);
      i_host.xfer(16'h1000, 8, q);
      chk({ckm, uni, bip, avg_en, avgc, repc, chan, scan}, 29'h10000000);
      $display("mode and reset test done");
      finish_test();
   end
endmodule // tb
